// ### core/i2c_slave_tx.sv
// I2C slave-transmitter section with status codes and set/clear control.
// Assumes open-drain pins resolved outside and a bus master slower than clk.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: Own address with read, acknowledged, raises the flag with status 0xA8.
// R2: If arbitration was lost just before such an address, status is 0xB0.
// R3: In 0xB0 software writes 0x24 to set start request and acknowledge.
// R4: A sent byte acknowledged by the master gives 0xB8 and another byte.
// R5: A sent byte without acknowledge gives 0xC0 and drops to not addressed.
// R6: The last byte, acknowledged, gives 0xC8 and drops to not addressed.
// R7: In 0xA8 and 0xB0 software loads the first byte before clearing the flag.
// R8: In 0xB8 software loads the next byte before clearing the flag.
// R9: Writing 0x04 to the set register sets the acknowledge bit.
// R10: Writing 0x08 to the clear register clears the flag and resumes the bus.
// R11: Writing 0x0C to the clear register clears flag and acknowledge together.
// R12: While the flag is set the clock is held low and the status stays put.
module i2c_slave_tx
  import i2c_stx_pkg::*;
(
  // System
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // I2C clock pin
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  // I2C data pin
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Master section of the controller
  input  wire logic        arb_lost,
  output logic             start_request,
  // Interrupt
  output logic             irq
);

  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_q_r;
  logic        sda_q_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  logic        ack_r;
  logic        req;
  logic        wr_go;
  logic [7:0]  wdata;
  logic [31:0] rdata_r;

  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  status_r;
  logic [7:0]  data_r;
  logic [7:0]  own_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_msk_r;
  logic [IRQ_W-1:0] ev;

  state_t      state_r;
  state_t      state_nxt;
  logic [7:0]  shift_r;
  logic [3:0]  cnt_r;
  logic        arb_r;
  logic        nack_r;
  logic        last_r;
  logic        si_set;
  logic [7:0]  code_nxt;
  logic        tx_load;
  logic        cnt_clr;
  logic        cnt_inc;
  logic        addr_hit;
  logic        sda_oe_r;
  logic        scl_oe_r;
  logic        hold_dly_r;

  // Pin inputs
  pin_sync #(
    .W       (2),
    .RST_VAL (2'b11)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({scl_in, sda_in}),
    .dout   (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q_r;
  assign scl_fall  = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // Bus slave: one wait cycle, then the access completes
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_go           = avs_write & ack_r & avs_byteenable[0];
  assign wdata           = avs_writedata[7:0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read data is latched in the wait cycle and stands at the taking edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      case (avs_address)
        OFS_CTRL_SET: rdata_r <= {24'h000000, ctrl_r};
        OFS_STAT:   rdata_r <= {24'h000000, status_r};
        OFS_DATA:   rdata_r <= {24'h000000, data_r};
        OFS_OWN:    rdata_r <= {24'h000000, own_r};
        OFS_IRQST:  rdata_r <= {29'h00000000, irq_st_r};
        OFS_IRQMSK: rdata_r <= {29'h00000000, irq_msk_r};
        default:    rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_r;

  // Control: software set and clear, hardware sets the flag
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_go && avs_address == OFS_CTRL_SET) begin
      ctrl_nxt = ctrl_r | (wdata & SET_MASK); // R3 R9
    end
    if (wr_go && avs_address == OFS_CTRL_CLR) begin
      ctrl_nxt = ctrl_r & ~(wdata & CLR_MASK); // R10 R11
    end
    if (si_set) begin
      // A new event beats a clear in the same cycle
      ctrl_nxt[SI_POS] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign start_request = ctrl_r[START_POS]; // R3

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_r <= DATA_RST;
      own_r  <= OWN_RST;
    end else begin
      if (wr_go && avs_address == OFS_DATA) begin
        data_r <= wdata;
      end
      if (wr_go && avs_address == OFS_OWN) begin
        own_r <= wdata;
      end
    end
  end

  // Interrupt status: sticky, write one to clear, set wins
  assign ev[EV_SI]   = si_set;
  assign ev[EV_DONE] = si_set & (code_nxt == ST_TX_NACK || code_nxt == ST_LAST_ACK);
  assign ev[EV_ARB]  = si_set & (code_nxt == ST_ARB_RD);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_st_r  <= '0;
      irq_msk_r <= MSK_RST;
    end else begin
      if (wr_go && avs_address == OFS_IRQST) begin
        irq_st_r <= (irq_st_r & ~wdata[IRQ_W-1:0]) | ev;
      end else begin
        irq_st_r <= irq_st_r | ev;
      end
      if (wr_go && avs_address == OFS_IRQMSK) begin
        irq_msk_r <= wdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_st_r & irq_msk_r);

  // Own address with read bit and acknowledge enabled
  assign addr_hit = (shift_r[7:1] == own_r[7:1]) & shift_r[0]
                  & ctrl_r[ACK_POS] & ctrl_r[EN_POS];

  // Transfer sequencing
  always_comb begin
    state_nxt = state_r;
    si_set    = 1'b0;
    code_nxt  = status_r;
    tx_load   = 1'b0;
    cnt_clr   = 1'b0;
    cnt_inc   = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (start_det && ctrl_r[EN_POS]) begin
          state_nxt = S_ADDR;
          cnt_clr   = 1'b1;
        end
      end
      S_ADDR: begin
        cnt_inc = scl_rise;
        if (scl_fall && cnt_r == CNT_BYTE) begin
          state_nxt = addr_hit ? S_AACK : S_IDLE;
        end
      end
      S_AACK: begin
        cnt_inc = scl_rise;
        if (scl_fall && cnt_r == CNT_ACK) begin
          state_nxt = S_HOLD;
          si_set    = 1'b1;
          code_nxt  = arb_r ? ST_ARB_RD : ST_ADR_RD; // R1 R2
        end
      end
      S_HOLD: begin
        // Clock stays low until software releases the flag
        if (!ctrl_r[SI_POS]) begin // R10 R12
          if (status_r == ST_TX_NACK || status_r == ST_LAST_ACK) begin
            state_nxt = S_IDLE; // R5 R6
          end else begin
            state_nxt = S_TX; // R4
            tx_load   = 1'b1;
            cnt_clr   = 1'b1;
          end
        end
      end
      S_TX: begin
        cnt_inc = scl_fall;
        if (scl_fall && cnt_r == CNT_LAST) begin
          state_nxt = S_MACK;
        end
      end
      S_MACK: begin
        cnt_inc = scl_rise;
        if (scl_fall && cnt_r == CNT_ACK) begin
          state_nxt = S_HOLD;
          si_set    = 1'b1;
          if (nack_r) begin
            code_nxt = ST_TX_NACK; // R5
          end else if (last_r) begin
            code_nxt = ST_LAST_ACK; // R6
          end else begin
            code_nxt = ST_TX_ACK; // R4
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    // Start from the master restarts, and stop abandons, any unheld transfer
    if (state_r != S_HOLD && state_r != S_IDLE) begin
      if (start_det) begin
        state_nxt = S_ADDR;
        cnt_clr   = 1'b1;
        cnt_inc   = 1'b0;
      end else if (stop_det) begin
        state_nxt = S_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Status changes when the flag is raised, and returns to idle when a finished transfer is released
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= ST_IDLE;
    end else if (si_set) begin
      status_r <= code_nxt; // R12
    end else if (state_r == S_HOLD && state_nxt == S_IDLE) begin
      status_r <= ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
    end else if (cnt_clr) begin
      cnt_r <= 4'h0;
    end else if (cnt_inc) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Address shifts in on rising clock, data shifts out on falling clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= 8'h00;
    end else if (tx_load) begin
      shift_r <= data_r; // R7 R8
    end else if (state_r == S_ADDR && scl_rise) begin
      shift_r <= {shift_r[6:0], sda_s};
    end else if (state_r == S_TX && scl_fall) begin
      shift_r <= {shift_r[6:0], 1'b1};
    end
  end

  // Acknowledge cleared before a byte marks it as the last one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      if (tx_load) begin
        last_r <= ~ctrl_r[ACK_POS]; // R6 R11
      end
      if (state_r == S_MACK && scl_rise) begin
        nack_r <= sda_s;
      end
    end
  end

  // Lost arbitration is remembered until the next own-address report
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arb_r <= 1'b0;
    end else if (arb_lost) begin
      arb_r <= 1'b1;
    end else if (si_set && state_r == S_AACK) begin
      arb_r <= 1'b0; // R2
    end
  end

  // Open-drain drives; clock release lags data by a cycle for setup
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_r   <= 1'b0;
      scl_oe_r   <= 1'b0;
      hold_dly_r <= 1'b0;
    end else begin
      sda_oe_r   <= (state_r == S_AACK) | ((state_r == S_TX) & ~shift_r[7]);
      hold_dly_r <= (state_r == S_HOLD);
      scl_oe_r   <= (state_r == S_HOLD) | hold_dly_r; // R12
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_r;
  assign scl_out = 1'b0;
  assign scl_oe  = scl_oe_r;

endmodule : i2c_slave_tx
`default_nettype wire

// ### inc/i2c_stx_pkg.sv
// Constants for the I2C slave-transmitter with its Avalon-MM registers.
// Assumes byte addresses on the register bus, one 32-bit word per register.
package i2c_stx_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL_SET = 5'h00;
  localparam logic [4:0] OFS_STAT   = 5'h04;
  localparam logic [4:0] OFS_DATA   = 5'h08;
  localparam logic [4:0] OFS_OWN    = 5'h0C;
  localparam logic [4:0] OFS_CTRL_CLR = 5'h10;
  localparam logic [4:0] OFS_IRQST  = 5'h14;
  localparam logic [4:0] OFS_IRQMSK = 5'h18;

  // Control bit positions
  localparam int ACK_POS = 2;
  localparam int SI_POS  = 3;
  localparam int STO_POS = 4;
  localparam int START_POS = 5;
  localparam int EN_POS  = 6;

  // Bits software may set or clear; the flag is set only by hardware
  localparam logic [7:0] SET_MASK = 8'h74;
  localparam logic [7:0] CLR_MASK = 8'h6C;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] MSK_RST  = 3'h0;

  // Status codes
  localparam logic [7:0] ST_ADR_RD   = 8'hA8;
  localparam logic [7:0] ST_ARB_RD   = 8'hB0;
  localparam logic [7:0] ST_TX_ACK   = 8'hB8;
  localparam logic [7:0] ST_TX_NACK  = 8'hC0;
  localparam logic [7:0] ST_LAST_ACK = 8'hC8;
  localparam logic [7:0] ST_IDLE     = 8'hF8;

  // Interrupt status bit positions
  localparam int IRQ_W  = 3;
  localparam int EV_SI   = 0;
  localparam int EV_DONE = 1;
  localparam int EV_ARB  = 2;

  // Bit counter marks
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [3:0] CNT_ACK  = 4'h9;
  localparam logic [3:0] CNT_LAST = 4'h7;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ADDR = 6'b000010,
    S_AACK = 6'b000100,
    S_HOLD = 6'b001000,
    S_TX   = 6'b010000,
    S_MACK = 6'b100000
  } state_t;

endpackage : i2c_stx_pkg

// ### core/pin_sync.sv
// Three-stage input synchroniser with an agreement filter per bit.
// Assumes asynchronous pin inputs; output moves when stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int         W       = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // System
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Pins and filtered result
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  if (W < 1) begin : g_chk
    $error("pin_sync needs at least one bit");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic out_r;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        s1_r  <= RST_VAL[i];
        s2_r  <= RST_VAL[i];
        s3_r  <= RST_VAL[i];
        out_r <= RST_VAL[i];
      end else begin
        s1_r <= din[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        // Single-cycle disagreement is treated as noise
        if (s2_r == s3_r) begin
          out_r <= s3_r;
        end
      end
    end
    assign dout[i] = out_r;
  end

endmodule : pin_sync
`default_nettype wire

// ### dv/i2c_slave_tx_asserts.sv
// Checker for register-bus handshake and pin timing of the slave-transmitter.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_tx_asserts
  import i2c_stx_pkg::*;
(
  // System
  input wire logic        clk,
  input wire logic        arst_n,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and side signals
  input wire logic        scl_in,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        start_request,
  input wire logic        irq
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic wdone = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire logic si_clr = wdone & (avs_address == OFS_CTRL_CLR) & avs_writedata[SI_POS];

  AST_ONE_WAIT: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access waited too long");
  AST_STA_SET: assert property (wdone && avs_address == OFS_CTRL_SET && avs_writedata[5] |=> start_request)
    else $error("start request not set");
  AST_STA_CLR: assert property (wdone && avs_address == OFS_CTRL_CLR && avs_writedata[5] |=> !start_request)
    else $error("start request not cleared");
  // Clear write, state change, delay stage and output flop: four cycles
  AST_SCL_RELEASE: assert property ($fell(scl_oe) |-> $past(si_clr, 2) || $past(si_clr, 3) || $past(si_clr, 4))
    else $error("clock released without flag clear");
  AST_HOLD_LOW: assert property ($rose(scl_oe) |-> !scl_in && $past(scl_in, 3) == 1'h0)
    else $error("clock hold not after a fall");
  AST_SDA_ON_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved while clock high");
  AST_IRQ_OFF: assert property (wdone && avs_address == OFS_IRQMSK && avs_writedata[2:0] == 3'h0 |=> !irq)
    else $error("masked interrupt still high");
  // Unmapped reads must not leak stale data
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address == 5'h1C |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : i2c_slave_tx_asserts

bind i2c_slave_tx i2c_slave_tx_asserts u_chk (
  .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .start_request(start_request), .irq(irq)
);
`default_nettype wire

// ### dv/i2c_master_model.sv
// Behavioural I2C bus master that reads from the slave.
// Assumes pulled-up wires resolved by the bench; waits out clock stretching.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int H = 20
) (
  // System
  input  wire logic clk,
  // Resolved wires
  input  wire logic scl_wire,
  input  wire logic sda_wire,
  // Pull-down enables
  output var logic  scl_pull,
  output var logic  sda_pull
);
  logic hung;

  initial begin
    scl_pull = 1'h0;
    sda_pull = 1'h0;
    hung = 1'h0;
  end

  // Release the clock; the slave may keep it low while its flag is set
  task automatic hi();
    int n;
    scl_pull <= 1'h0;
    n = 0;
    while (!scl_wire && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) hung = 1'h1;
    repeat (H) @(posedge clk);
  endtask : hi

  task automatic bit_x(input logic b, output logic r);
    sda_pull <= ~b;
    repeat (H / 2) @(posedge clk);
    hi();
    r = sda_wire;
    scl_pull <= 1'h1;
    repeat (H) @(posedge clk);
  endtask : bit_x

  task automatic start_c();
    sda_pull <= 1'h0;
    hi();
    sda_pull <= 1'h1;
    repeat (H) @(posedge clk);
    scl_pull <= 1'h1;
    repeat (H) @(posedge clk);
  endtask : start_c

  task automatic stop_c();
    sda_pull <= 1'h1;
    repeat (H / 2) @(posedge clk);
    hi();
    sda_pull <= 1'h0;
    repeat (H) @(posedge clk);
  endtask : stop_c

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'h1, ack);
  endtask : wbyte

  // Bits arrive most significant first
  task automatic rbyte(input logic ak, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_x(1'h1, r);
      d = {d[6:0], r};
    end
    bit_x(ak, r);
  endtask : rbyte
endmodule : i2c_master_model
`default_nettype wire

// ### dv/i2c_slave_tx_test.sv
// Self-checking bench for the slave-transmitter: registers, then two reads.
// Assumes the master model and checker files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_tx_test
  import i2c_stx_pkg::*;
;
  typedef struct {
    logic [4:0] wa;
    logic [7:0] wv;
    logic [4:0] ra;
    logic [7:0] ex;
  } row_t;
  row_t rows [12] = '{
    '{5'h00, 8'h24, 5'h00, 8'h24},
    '{5'h10, 8'h2C, 5'h00, 8'h00},
    '{5'h00, 8'h04, 5'h00, 8'h04},
    '{5'h10, 8'h0C, 5'h00, 8'h00},
    '{5'h00, 8'h48, 5'h00, 8'h40},
    '{5'h04, 8'h00, 5'h04, 8'hF8},
    '{5'h08, 8'hA5, 5'h08, 8'hA5},
    '{5'h0C, 8'hA0, 5'h0C, 8'hA0},
    '{5'h1C, 8'hFF, 5'h1C, 8'h00},
    '{5'h18, 8'h00, 5'h18, 8'h00},
    '{5'h18, 8'h07, 5'h18, 8'h07},
    '{5'h00, 8'h04, 5'h00, 8'h44}
  };
  logic        clk, arst_n, rd, we, arb, ak;
  logic [4:0]  adr;
  logic [31:0] wdat;
  logic [7:0]  r, d0, d1, d2;
  int          error_cnt, num_checks;
  wire logic [31:0] rdata;
  wire logic   wq, scl_oe, sda_oe, sreq, irq, scl_pull, sda_pull;
  // Pull-up wires: low while anyone pulls
  wire logic   scl_w = ~(scl_oe | scl_pull);
  wire logic   sda_w = ~(sda_oe | sda_pull);

  i2c_slave_tx u_dut (
    .clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd), .avs_write(we),
    .avs_byteenable(4'hF), .avs_writedata(wdat), .avs_readdata(rdata), .avs_waitrequest(wq),
    .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe),
    .arb_lost(arb), .start_request(sreq), .irq(irq)
  );
  i2c_master_model u_mst (
    .clk(clk), .scl_wire(scl_w), .sda_wire(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull)
  );

  always #12.5 clk = ~clk;

  task test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask : chk

  task tmo();
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    test_done();
  endtask : tmo

  // Request held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    @(posedge clk);
    adr <= a;
    wdat <= {24'h0, d};
    rd <= ~w;
    we <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'h0 && n < 50);
    if (n >= 50) tmo();
    q = rdata[7:0];
    rd <= 1'h0;
    we <= 1'h0;
  endtask : acc

  task automatic srv(input logic [7:0] st, ie, d, sv, cv, input logic ld);
    int n;
    logic [7:0] q;
    n = 0;
    while (irq !== 1'h1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000) tmo();
    acc(1'h0, OFS_STAT, 8'h00, q);
    chk(q, st);
    acc(1'h0, OFS_IRQST, 8'h00, q);
    chk(q, ie);
    if (ld) acc(1'h1, OFS_DATA, d, q);
    acc(1'h1, 5'h00, sv, q);
    acc(1'h0, OFS_STAT, 8'h00, q);
    chk(q, st);
    acc(1'h1, OFS_IRQST, 8'h07, q);
    @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    acc(1'h1, 5'h10, cv, q);
  endtask : srv

  initial begin
    clk = 1'h0;
    arst_n = 1'h0;
    {rd, we, arb, adr, wdat} = '0;
    error_cnt = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    foreach (rows[i]) begin
      acc(1'h1, rows[i].wa, rows[i].wv, r);
      acc(1'h0, rows[i].ra, 8'h00, r);
      chk(r, rows[i].ex);
    end
    $display("register rows done");
    fork
      begin
        u_mst.start_c();
        u_mst.wbyte(8'hA1, ak);
        chk({7'h00, ak}, 8'h00);
        u_mst.rbyte(1'h0, d0);
        u_mst.rbyte(1'h0, d1);
        u_mst.stop_c();
      end
      begin
        srv(ST_ADR_RD, 8'h01, 8'hA5, 8'h04, 8'h08, 1'h1);
        srv(ST_TX_ACK, 8'h01, 8'h3C, 8'h04, 8'h0C, 1'h1);
        srv(ST_LAST_ACK, 8'h03, 8'h00, 8'h04, 8'h08, 1'h0);
      end
    join
    chk(d0, 8'hA5);
    chk(d1, 8'h3C);
    $display("read with last byte done");
    @(posedge clk);
    arb <= 1'h1;
    @(posedge clk);
    arb <= 1'h0;
    fork
      begin
        u_mst.start_c();
        u_mst.wbyte(8'hA1, ak);
        u_mst.rbyte(1'h1, d2);
        u_mst.stop_c();
      end
      begin
        srv(ST_ARB_RD, 8'h05, 8'h81, 8'h24, 8'h08, 1'h1);
        chk({7'h00, sreq}, 8'h01);
        srv(ST_TX_NACK, 8'h03, 8'h00, 8'h04, 8'h08, 1'h0);
      end
    join
    chk(d2, 8'h81);
    acc(1'h0, OFS_STAT, 8'h00, r);
    chk(r, ST_IDLE);
    $display("lost arbitration then no ack done");
    @(posedge clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    acc(1'h0, OFS_STAT, 8'h00, r);
    chk(r, ST_IDLE);
    acc(1'h0, 5'h00, 8'h00, r);
    chk(r, CTRL_RST);
    acc(1'h0, OFS_IRQMSK, 8'h00, r);
    chk(r, 8'h00);
    chk({6'h00, sreq, irq}, 8'h00);
    chk({7'h00, u_mst.hung}, 8'h00);
    $display("reset values done");
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clk);
    tmo();
  end
endmodule : i2c_slave_tx_test
`default_nettype wire
